// ==== rtl/pic_pkg.sv ====
// Purpose: Shared constants and carriers for the priority interrupt controller
// Assumes: Single clock domain, all configuration supplied as plain ports
// Notes:   Source numbers index the vector table directly
package pic_pkg;
  localparam int unsigned NUM_SRC   = 86;
  localparam int unsigned VEC_W     = 7;
  localparam int unsigned LVL_W     = 2;
  localparam int unsigned BASE_W    = 14;
  localparam int unsigned ADDR_W    = BASE_W + VEC_W;
  localparam int unsigned FLO_W     = 16;
  localparam int unsigned FHI_W     = ADDR_W - FLO_W;
  localparam int unsigned NUM_LVL   = 4;
  localparam int unsigned PRIO_W    = NUM_SRC * LVL_W;

  localparam logic [VEC_W-1:0]  EXT_A_IDX   = 7'h0_002;
  localparam logic [VEC_W-1:0]  EXT_B_IDX   = 7'h0_003;
  localparam logic [LVL_W-1:0]  PRIO_OFF    = 2'h0;
  localparam logic [LVL_W-1:0]  FAST_LVL    = 2'h2;
  localparam logic [ADDR_W-1:0] RESET_ADDR  = 21'h00_0000;
  localparam logic [BASE_W-1:0] BASE_RST    = 14'h0_000;

  typedef struct packed {
    logic [VEC_W-1:0] match;
    logic [FLO_W-1:0] addr_low;
    logic [FHI_W-1:0] addr_high;
  } pic_fast_cfg_t;

  typedef struct packed {
    logic              pending;
    logic              fast;
    logic [LVL_W-1:0]  level;
    logic [VEC_W-1:0]  vec_num;
    logic [ADDR_W-1:0] vec_addr;
  } pic_sel_t;

  typedef enum logic [1:0] {
    PIC_BOOT = 2'b01,
    PIC_RUN  = 2'b10
  } pic_state_t;
endpackage

// ==== rtl/pic_lowest_enc.sv ====
// Purpose: Lowest-index priority encoder over all sources
// Assumes: Request vector is stable within the cycle
// Notes:   Purely combinational; one instance per priority level
`timescale 1ns/1ps
`default_nettype none
module pic_lowest_enc (
  input  wire logic [pic_pkg::NUM_SRC-1:0] req_i,   // Active requests of one level
  output logic                             found_o, // Any request active
  output logic [pic_pkg::VEC_W-1:0]        idx_o    // Lowest active index
);
  always_comb
  begin
    found_o = 1'b0;
    idx_o   = '0;
    // Scan downward so the lowest index is written last
    for (int i = pic_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      if (req_i[i])
      begin
        found_o = 1'b1;
        idx_o   = pic_pkg::VEC_W'(i);
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/pic_arbiter.sv ====
// Purpose: Priority interrupt controller (interrupt_arbiter_unit) top level
// Assumes: Inputs synchronous to mclk_i; configuration arrives as plain ports
// Notes:   Selection is registered, so the address trails a level request by one cycle and an edge-mode external request by two
//
// How it works
// [RULE1] Eighty-six sources, each programmable to one of four levels.
// [RULE2] Within a level the lowest active vector number wins.
// [RULE3] Normal vector address is vector base joined with vector number.
// [RULE4] Pending flag and jump address are presented to the core.
// [RULE5] Core mask bits: 00 all, 01 drops 0, 10 drops 0-1, 11 only 3.
// [RULE6] Current level code must be reached; code 11 admits only level 3.
// [RULE7] Software sets fast source to level 2 and loads match and address.
// [RULE8] Level 2 request matching a fast slot uses that slot's address.
// [RULE9] Fast address is already presented before the core accepts.
// [RULE10] Core starts fast handling only if fetched op is not subroutine jump.
// [RULE11] After reset the initial fetch address is driven out.
// [RULE12] Functional mode is entered at reset without configuration.
// [RULE13] In wait or stop a pending request asks for clocks to restart.
// [RULE14] Only requests enabled before low-power entry may wake.
// [RULE15] External requests turn low-level sensitive in wait and stop.
// [RULE16] In stop only CAN, external requests and reset can wake.
// [RULE17] Priority, vector and match settings are reachable by software.
// [RULE18] Priority code 00 disables; nonzero codes start at level 0 or 1.
// [RULE19] Vector number is carried on seven bits.
`timescale 1ns/1ps
`default_nettype none
module pic_arbiter (
  input  wire logic                         mclk_i,            // System clock, 125 MHz
  input  wire logic                         rst_n_i,           // Sync reset, active low
  input  wire logic [pic_pkg::NUM_SRC-1:0]  irq_req_i,         // Peripheral requests, high
  input  wire logic                         ext_request_a_n_i, // External request A pin
  input  wire logic                         ext_request_b_n_i, // External request B pin
  input  wire logic                         ext_a_edge_i,      // A falling-edge mode
  input  wire logic                         ext_b_edge_i,      // B falling-edge mode
  input  wire logic [pic_pkg::PRIO_W-1:0]   prio_code_i,       // Two-bit code per source [RULE17]
  input  wire logic [pic_pkg::NUM_SRC-1:0]  prio_from0_i,      // Codes start at level 0
  input  wire logic [pic_pkg::BASE_W-1:0]   vector_base_value_i, // Vector table base
  input  wire pic_pkg::pic_fast_cfg_t       fast_cfg_0_i,      // Fast slot 0 settings
  input  wire pic_pkg::pic_fast_cfg_t       fast_cfg_1_i,      // Fast slot 1 settings
  input  wire logic [1:0]                   core_mask_i,       // Core status word mask
  input  wire logic [pic_pkg::LVL_W-1:0]    current_level_code_i, // Level in service
  input  wire logic                         ack_i,             // Core took the exception
  input  wire logic [pic_pkg::VEC_W-1:0]    ack_vec_i,         // Vector taken by core
  input  wire logic                         wait_mode_i,       // Wait mode active
  input  wire logic                         stop_mode_i,       // Stop mode active
  input  wire logic [pic_pkg::NUM_SRC-1:0]  stop_wake_src_i,   // Sources alive in stop
  output pic_pkg::pic_sel_t                 sel_o,             // Registered selection
  output logic [pic_pkg::ADDR_W-1:0]        addr_o,            // Fetch or vector address
  output logic                              boot_fetch_o,      // Initial fetch cycle
  output logic                              wake_o             // Clock restart request
);
  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Returns {enabled, level} for a code and its numbering start
  function automatic logic [2:0] eff_level(input logic [1:0] code, input logic from0);
    logic [1:0] lvl;
    lvl = from0 ? (code - 2'h1) : code;
    eff_level = {code != pic_pkg::PRIO_OFF, lvl};
  endfunction

  // Shared by core mask and current level code: both need level >= code
  function automatic logic level_ok(input logic [1:0] lvl, input logic [1:0] code);
    level_ok = (lvl >= code);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  pic_pkg::pic_state_t            state_reg, state_next;
  pic_pkg::pic_sel_t              sel_reg, sel_next;
  logic [pic_pkg::NUM_SRC-1:0]    en_snap_reg, en_snap_next;
  logic                           lp_prev_reg, lp_prev_next;
  logic                           wake_reg, wake_next;
  logic [1:0]                     pin_prev_reg, pin_prev_next;
  logic [1:0]                     edge_pend_reg, edge_pend_next;

  logic                           low_power;
  logic [1:0]                     pin_low;
  logic [1:0]                     edge_mode;
  logic [pic_pkg::VEC_W-1:0]      ext_idx [2];
  logic [pic_pkg::NUM_SRC-1:0]    src_req;
  logic [pic_pkg::NUM_SRC-1:0]    src_en;
  logic [pic_pkg::NUM_SRC-1:0]    lvl_req [pic_pkg::NUM_LVL];
  logic [pic_pkg::NUM_LVL-1:0]    lvl_found;
  logic [pic_pkg::VEC_W-1:0]      lvl_idx [pic_pkg::NUM_LVL];

  assign low_power  = wait_mode_i | stop_mode_i;
  assign pin_low    = {~ext_request_b_n_i, ~ext_request_a_n_i};
  assign edge_mode  = {ext_b_edge_i, ext_a_edge_i};
  assign ext_idx[0] = pic_pkg::EXT_A_IDX;
  assign ext_idx[1] = pic_pkg::EXT_B_IDX;

  // ---------------------------------------------------------------
  // Source conditioning and level sorting
  // ---------------------------------------------------------------
  genvar gs;
  generate
    for (gs = 0; gs < pic_pkg::NUM_SRC; gs++)
    begin : g_src
      logic [2:0] el;
      logic       raw;
      assign el = eff_level(prio_code_i[gs*2 +: 2], prio_from0_i[gs]);  // [RULE1] [RULE18]
      always_comb
      begin
        raw = irq_req_i[gs];
        if (gs == int'(pic_pkg::EXT_A_IDX))
          raw = (edge_mode[0] && !low_power) ? edge_pend_reg[0] : pin_low[0];  // [RULE15]
        else if (gs == int'(pic_pkg::EXT_B_IDX))
          raw = (edge_mode[1] && !low_power) ? edge_pend_reg[1] : pin_low[1];  // [RULE15]
      end
      assign src_req[gs] = raw;
      assign src_en[gs]  = el[2];
      for (genvar gl = 0; gl < pic_pkg::NUM_LVL; gl++)
      begin : g_lvl
        assign lvl_req[gl][gs] = raw && el[2] && (el[1:0] == 2'(gl));
      end
    end

    for (gs = 0; gs < pic_pkg::NUM_LVL; gs++)
    begin : g_enc
      pic_lowest_enc u_enc (                                         // [RULE2]
        .req_i   (lvl_req[gs]),
        .found_o (lvl_found[gs]),
        .idx_o   (lvl_idx[gs])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [1:0]                    lvl;
    logic [pic_pkg::VEC_W-1:0]     num;
    logic                          hit0;
    logic                          hit1;
    logic [pic_pkg::NUM_SRC-1:0]   wake_src;
    lvl      = '0;
    num      = '0;
    hit0     = 1'b0;
    hit1     = 1'b0;
    wake_src = '0;

    state_next = pic_pkg::PIC_RUN;                                   // [RULE12]
    unique case (state_reg)
      pic_pkg::PIC_BOOT: state_next = pic_pkg::PIC_RUN;
      pic_pkg::PIC_RUN:  state_next = pic_pkg::PIC_RUN;
      default:           state_next = pic_pkg::PIC_RUN;
    endcase

    // Highest accepted level wins; within it the encoder picked the number
    sel_next = '0;
    for (int l = 0; l < pic_pkg::NUM_LVL; l++)
    begin
      if (lvl_found[l] && level_ok(2'(l), core_mask_i)               // [RULE5]
          && level_ok(2'(l), current_level_code_i))                  // [RULE6]
      begin
        lvl = 2'(l);
        num = lvl_idx[l];                                            // [RULE19]
        sel_next.pending = 1'b1;                                     // [RULE4]
      end
    end
    hit0 = (num == fast_cfg_0_i.match);
    hit1 = (num == fast_cfg_1_i.match);
    sel_next.level   = lvl;
    sel_next.vec_num = num;
    // Fast decision made here, ahead of the core's acceptance
    sel_next.fast    = sel_next.pending && (lvl == pic_pkg::FAST_LVL)
                       && (hit0 || hit1);                            // [RULE8] [RULE9]
    if (sel_next.fast && hit0)
      sel_next.vec_addr = {fast_cfg_0_i.addr_high, fast_cfg_0_i.addr_low};  // [RULE8]
    else if (sel_next.fast)
      sel_next.vec_addr = {fast_cfg_1_i.addr_high, fast_cfg_1_i.addr_low};  // [RULE8]
    else
      sel_next.vec_addr = {vector_base_value_i, num};                // [RULE3]

    // Falling-edge catch; a new edge in the ack cycle is kept
    pin_prev_next  = pin_low;
    edge_pend_next = edge_pend_reg;
    for (int e = 0; e < 2; e++)
    begin
      if (ack_i && (ack_vec_i == ext_idx[e]))
        edge_pend_next[e] = 1'b0;
      // Only latch in edge mode, so a later switch to edge mode sees no stale edge
      if (edge_mode[e] && pin_low[e] && !pin_prev_reg[e])
        edge_pend_next[e] = 1'b1;                                    // [RULE15]
    end

    // Enable set frozen at the moment of low-power entry
    lp_prev_next = low_power;
    en_snap_next = en_snap_reg;
    if (low_power && !lp_prev_reg)
      en_snap_next = src_en;                                         // [RULE14]
    wake_src = src_req & en_snap_reg;
    if (stop_mode_i)
      wake_src = wake_src & stop_wake_src_i;                         // [RULE16]
    wake_next = low_power && lp_prev_reg && (|wake_src);             // [RULE13]
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg     <= pic_pkg::PIC_BOOT;
      sel_reg       <= '0;
      en_snap_reg   <= '0;
      lp_prev_reg   <= 1'b0;
      wake_reg      <= 1'b0;
      pin_prev_reg  <= 2'h0;
      edge_pend_reg <= 2'h0;
    end
    else
    begin
      state_reg     <= state_next;
      sel_reg       <= sel_next;
      en_snap_reg   <= en_snap_next;
      lp_prev_reg   <= lp_prev_next;
      wake_reg      <= wake_next;
      pin_prev_reg  <= pin_prev_next;
      edge_pend_reg <= edge_pend_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Reset address held through reset and the first cycle after it
  assign boot_fetch_o = (state_reg == pic_pkg::PIC_BOOT);            // [RULE11]
  assign addr_o       = boot_fetch_o ? pic_pkg::RESET_ADDR : sel_reg.vec_addr;  // [RULE11]
  assign sel_o        = sel_reg;
  assign wake_o       = wake_reg;
endmodule
`default_nettype wire

// ==== testbench/pic_arbiter_props.sv ====
// Purpose: Concurrent checks on the arbiter ports
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound into every pic_arbiter instance
`timescale 1ns/1ps
`default_nettype none
module pic_arbiter_props (
  input wire logic                       mclk_i,               // Clock
  input wire logic                       rst_n_i,              // Reset
  input wire logic [pic_pkg::PRIO_W-1:0] prio_code_i,          // Codes
  input wire logic [pic_pkg::BASE_W-1:0] vector_base_value_i,  // Base
  input wire logic [1:0]                 core_mask_i,          // Mask
  input wire logic [pic_pkg::LVL_W-1:0]  current_level_code_i, // Level
  input wire logic                       wait_mode_i,          // Wait
  input wire logic                       stop_mode_i,          // Stop
  input wire pic_pkg::pic_sel_t          sel_o,                // Select
  input wire logic [pic_pkg::ADDR_W-1:0] addr_o,               // Address
  input wire logic                       boot_fetch_o,         // Boot
  input wire logic                       wake_o                // Wake
);
  // --------
  // Checks
  // --------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_released;
    rst_n_i ##1 rst_n_i;
  endsequence
  a_boot_addr: assert property (boot_fetch_o |-> addr_o == pic_pkg::RESET_ADDR)
    else $error("boot address wrong");
  a_boot_ends: assert property (s_released |-> !boot_fetch_o)
    else $error("boot fetch did not end");
  a_addr_follows: assert property (!boot_fetch_o |-> addr_o == sel_o.vec_addr)
    else $error("address not selection");
  a_normal_addr: assert property (sel_o.pending && !sel_o.fast |->
    sel_o.vec_addr == {$past(vector_base_value_i), sel_o.vec_num}) else $error("normal addr");
  a_mask_gate: assert property (sel_o.pending |->
    sel_o.level >= $past(core_mask_i) && sel_o.level >= $past(current_level_code_i))
    else $error("masked level taken");
  a_fast_level: assert property (sel_o.fast |->
    sel_o.pending && sel_o.level == pic_pkg::FAST_LVL) else $error("fast not level 2");
  a_vec_range: assert property (sel_o.pending |->
    sel_o.vec_num < pic_pkg::NUM_SRC) else $error("vector out of range");
  a_off_silent: assert property ($past(prio_code_i) == '0 |-> !sel_o.pending)
    else $error("disabled source taken");
  a_wake_lowpow: assert property (wake_o |-> $past(wait_mode_i || stop_mode_i))
    else $error("wake outside low power");
endmodule
bind pic_arbiter pic_arbiter_props u_props (.mclk_i, .rst_n_i, .prio_code_i,
  .vector_base_value_i, .core_mask_i, .current_level_code_i, .wait_mode_i,
  .stop_mode_i, .sel_o, .addr_o, .boot_fetch_o, .wake_o);
`default_nettype wire

// ==== testbench/pic_core_model.sv ====
// Purpose: Core side: takes offered exceptions when told to
// Assumes: Acknowledge is a one-cycle pulse
// Notes:   Idle vector lines toggle so stale values never match
`timescale 1ns/1ps
`default_nettype none
module pic_core_model (
  input  wire logic                      mclk_i,    // Clock
  input  wire logic                      rst_n_i,   // Reset
  input  wire pic_pkg::pic_sel_t         sel_i,     // Offered selection
  input  wire logic                      take_i,    // Accept if offered
  input  wire logic                      jump_i,    // Fetched op is a jump
  output logic                           ack_o,     // Exception taken
  output logic [pic_pkg::VEC_W-1:0]      ack_vec_o, // Vector taken
  output logic                           fast_o     // Fast handling began
);
  // --------
  // Accept
  // --------
  wire logic go = take_i && sel_i.pending && !ack_o;
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      ack_o <= 1'h0;
      ack_vec_o <= '0;
      fast_o <= 1'h0;
    end
    else
    begin
      ack_o <= go;
      ack_vec_o <= go ? sel_i.vec_num : ~ack_vec_o;
      if (go)
        fast_o <= sel_i.fast && !jump_i;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the arbiter
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Each scenario judges its own results
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk_i, rst_n_i, wait_mode_i, stop_mode_i, ack_i, take, jump, fast_run;
  logic [1:0] ext_n, ext_edge, core_mask_i, current_level_code_i;
  logic [pic_pkg::NUM_SRC-1:0] irq_req_i, prio_from0_i, stop_wake_src_i;
  logic [pic_pkg::PRIO_W-1:0] prio_code_i;
  logic [pic_pkg::BASE_W-1:0] vector_base_value_i;
  logic [pic_pkg::VEC_W-1:0] ack_vec_i;
  logic [pic_pkg::ADDR_W-1:0] addr_o;
  logic boot_fetch_o, wake_o;
  pic_pkg::pic_fast_cfg_t fast_cfg_0_i, fast_cfg_1_i;
  pic_pkg::pic_sel_t sel_o;
  int n_errors, comparisons;
  pic_arbiter dut (.mclk_i, .rst_n_i, .irq_req_i, .ext_request_a_n_i(ext_n[0]),
    .ext_request_b_n_i(ext_n[1]), .ext_a_edge_i(ext_edge[0]), .ext_b_edge_i(ext_edge[1]),
    .prio_code_i, .prio_from0_i, .vector_base_value_i, .fast_cfg_0_i, .fast_cfg_1_i,
    .core_mask_i, .current_level_code_i, .ack_i, .ack_vec_i, .wait_mode_i, .stop_mode_i,
    .stop_wake_src_i, .sel_o, .addr_o, .boot_fetch_o, .wake_o);
  pic_core_model core (.mclk_i, .rst_n_i, .sel_i(sel_o), .take_i(take), .jump_i(jump),
    .ack_o(ack_i), .ack_vec_o(ack_vec_i), .fast_o(fast_run));
  // --------
  // Helpers
  // --------
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic setp(input int i, input logic [1:0] c, input logic f);
    prio_code_i[2*i +: 2] = c;
    prio_from0_i[i] = f;
  endtask
  task automatic accept(input logic j);
    jump = j;
    take = 1'h1;
    step(1);
    take = 1'h0;
  endtask
  task automatic summarize();
    $display("TB: %0d errors in %0d comparisons", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // --------
  // Scenarios
  // --------
  task automatic t_lowest();
    vector_base_value_i = 14'h2a5c;
    setp(0, 2'h1, 1'h0);
    setp(40, 2'h1, 1'h0);
    setp(85, 2'h1, 1'h0);
    irq_req_i[0] = 1'h1;
    irq_req_i[40] = 1'h1;
    irq_req_i[85] = 1'h1;
    step(1);
    chk(sel_o.vec_num, 7'h00);
    irq_req_i[0] = 1'h0;
    step(1);
    chk(sel_o.vec_num, 7'h28);
    irq_req_i[40] = 1'h0;
    step(1);
    chk(addr_o, {14'h2a5c, 7'h55});
    irq_req_i = '0;
    prio_code_i = '0;
  endtask
  task automatic t_levels();
    irq_req_i[10] = 1'h1;
    for (int l = 0; l < 4; l++)
      for (int m = 0; m < 4; m++)
        for (int c = 0; c < 4; c++)
        begin
          setp(10, (l == 0) ? 2'h1 : 2'(l), l == 0);
          core_mask_i = 2'(m);
          current_level_code_i = 2'(c);
          step(1);
          chk(sel_o.pending, l >= m && l >= c);
          if (sel_o.pending === 1'h1)
            chk(sel_o.level, l);
        end
    core_mask_i = 2'h0;
    current_level_code_i = 2'h0;
    setp(10, 2'h0, 1'h0);
    step(1);
    chk(sel_o.pending, 1'h0);
    irq_req_i = '0;
  endtask
  task automatic t_fast();
    setp(20, 2'h2, 1'h0);
    setp(21, 2'h2, 1'h0);
    fast_cfg_0_i = '{7'h14, 16'h1234, 5'h0a};
    fast_cfg_1_i = '{7'h15, 16'h5678, 5'h03};
    irq_req_i[20] = 1'h1;
    step(1);
    chk(addr_o, 21'h0a_1234);
    accept(1'h0);
    chk(fast_run, 1'h1);
    step(1);
    accept(1'h1);
    chk(fast_run, 1'h0);
    irq_req_i = 86'h20_0000;
    step(1);
    chk(addr_o, 21'h03_5678);
    irq_req_i = 86'h10_0000;
    fast_cfg_1_i.match = 7'h14;
    step(1);
    chk(addr_o, 21'h0a_1234);
    setp(20, 2'h1, 1'h0);
    step(1);
    chk(sel_o.fast, 1'h0);
    chk(addr_o, {14'h2a5c, 7'h14});
    irq_req_i = '0;
    prio_code_i = '0;
  endtask
  task automatic t_ext();
    for (int k = 0; k < 2; k++)
    begin
      setp(2 + k, 2'h1, 1'h0);
      ext_edge[k] = 1'h1;
      ext_n[k] = 1'h0;
      step(2);
      chk(sel_o.vec_num, 2 + k);
      ext_n[k] = 1'h1;
      step(2);
      chk(sel_o.pending, 1'h1);
      accept(1'h0);
      step(2);
      chk(sel_o.pending, 1'h0);
      ext_edge[k] = 1'h0;
      ext_n[k] = 1'h0;
      step(1);
      chk(sel_o.pending, 1'h1);
      ext_n[k] = 1'h1;
      step(1);
      chk(sel_o.pending, 1'h0);
    end
  endtask
  task automatic t_wake();
    setp(5, 2'h1, 1'h0);
    wait_mode_i = 1'h1;
    step(1);
    setp(6, 2'h1, 1'h0);
    irq_req_i[6] = 1'h1;
    step(1);
    chk(wake_o, 1'h0);
    irq_req_i[5] = 1'h1;
    step(1);
    chk(wake_o, 1'h1);
    wait_mode_i = 1'h0;
    ext_edge = 2'h3;
    stop_wake_src_i[2] = 1'h1;
    step(1);
    chk(wake_o, 1'h0);
    stop_mode_i = 1'h1;
    step(2);
    chk(wake_o, 1'h0);
    ext_n[0] = 1'h0;
    step(1);
    chk(wake_o, 1'h1);
    stop_mode_i = 1'h0;
    ext_n = 2'h3;
  endtask
  // --------
  // Run
  // --------
  initial
  begin
    mclk_i = 1'h0;
    forever #4 mclk_i = ~mclk_i;
  end
  initial
  begin
    #100000;
    n_errors++;
    summarize();
  end
  initial
  begin
    {rst_n_i, wait_mode_i, stop_mode_i, take, jump, ext_edge} = '0;
    {core_mask_i, current_level_code_i, irq_req_i, prio_from0_i} = '0;
    {stop_wake_src_i, prio_code_i, vector_base_value_i} = '0;
    {fast_cfg_0_i, fast_cfg_1_i} = '0;
    ext_n = 2'h3;
    step(3);
    chk(boot_fetch_o, 1'h1);
    chk(addr_o, pic_pkg::RESET_ADDR);
    rst_n_i = 1'h1;
    step(1);
    chk(boot_fetch_o, 1'h0);
    t_lowest();
    t_levels();
    t_fast();
    t_ext();
    t_wake();
    rst_n_i = 1'h0;
    step(1);
    chk(addr_o, pic_pkg::RESET_ADDR);
    rst_n_i = 1'h1;
    step(2);
    summarize();
  end
endmodule
`default_nettype wire
